// [rtl/supply_fault_lockout_logic.sv]
// Control logic behind the undervoltage, input overvoltage and output overvoltage comparators.
// Assumes comparators are asynchronous levels and the register master never waits.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module supply_fault_lockout_logic (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [supply_fault_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [supply_fault_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [supply_fault_pkg::DATA_W-1:0] reg_rdata,
	input wire logic undervolt_cmp,
	input wire logic input_overvolt_cmp,
	input wire logic output_overvolt_cmp,
	input wire logic primary_gate_req,
	input wire logic secondary_gate_req,
	output logic [supply_fault_pkg::CODE_W-1:0] undervolt_code,
	output logic [supply_fault_pkg::CODE_W-1:0] input_overvolt_code,
	output logic [supply_fault_pkg::LEVEL_W-1:0] output_overvolt_code,
	output logic primary_gate_out,
	output logic secondary_gate_out,
	output logic [supply_fault_pkg::NUM_CMP-1:0] fault_flags
);
	localparam int N = supply_fault_pkg::NUM_CMP;
	logic [N-1:0] cmp_raw;
	logic [N-1:0] sync1_q, sync1_d;
	logic [N-1:0] sync2_q, sync2_d;
	logic [N-1:0] prev_q, prev_d;
	logic [N-1:0] en_q, en_d;
	logic [N-1:0] rise_sel_q, rise_sel_d;
	logic [N-1:0] fall_sel_q, fall_sel_d;
	logic [N-1:0] flag_q, flag_d;
	logic [N-1:0] edge_hit;
	logic [N-1:0] flag_clr;
	logic [supply_fault_pkg::CODE_W-1:0] uv_code_q, uv_code_d;
	logic [supply_fault_pkg::CODE_W-1:0] iov_code_q, iov_code_d;
	logic [supply_fault_pkg::LEVEL_W-1:0] oov_code_q, oov_code_d;
	logic [supply_fault_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic pgate_q, pgate_d;
	logic sgate_q, sgate_d;
	logic wr_lock, wr_out, wr_flags;

	assign cmp_raw[supply_fault_pkg::CMP_UV] = undervolt_cmp;
	assign cmp_raw[supply_fault_pkg::CMP_IOV] = input_overvolt_cmp;
	// Comparator itself decides sense above reference
	assign cmp_raw[supply_fault_pkg::CMP_OOV] = output_overvolt_cmp; // RULE16

	assign wr_lock = reg_wr && (reg_addr == supply_fault_pkg::ADDR_LOCKOUT_CTRL);
	assign wr_out = reg_wr && (reg_addr == supply_fault_pkg::ADDR_OUT_OV_CTRL);
	assign wr_flags = reg_wr && (reg_addr == supply_fault_pkg::ADDR_FLAGS);

	// Synchronizer and edge history
	always_comb begin
		sync1_d = cmp_raw;
		sync2_d = sync1_q; // RULE23
		prev_d = sync2_q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q <= prev_d;
		end
	end

	// Per comparator edge qualification and sticky flag
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_flag
			// Enable bits deliberately play no part here
			assign edge_hit[gi] = (rise_sel_q[gi] && sync2_q[gi] && !prev_q[gi]) ||
				(fall_sel_q[gi] && !sync2_q[gi] && prev_q[gi]); // RULE1 RULE11 RULE12 RULE18 RULE20
			// Write zero to a bit clears it, write one leaves it
			assign flag_clr[gi] = wr_flags && !reg_wdata[gi];
		end
	endgenerate

	always_comb begin
		flag_d = (flag_q & ~flag_clr) | edge_hit; // RULE24
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// Control and threshold registers
	always_comb begin
		en_d = en_q;
		rise_sel_d = rise_sel_q;
		fall_sel_d = fall_sel_q;
		uv_code_d = uv_code_q;
		iov_code_d = iov_code_q;
		oov_code_d = oov_code_q;
		if (wr_lock) begin
			en_d[supply_fault_pkg::CMP_UV] = reg_wdata[supply_fault_pkg::UV_EN_BIT];
			rise_sel_d[supply_fault_pkg::CMP_UV] = reg_wdata[supply_fault_pkg::UV_RISE_BIT];
			fall_sel_d[supply_fault_pkg::CMP_UV] = reg_wdata[supply_fault_pkg::UV_FALL_BIT];
			en_d[supply_fault_pkg::CMP_IOV] = reg_wdata[supply_fault_pkg::IOV_EN_BIT];
			rise_sel_d[supply_fault_pkg::CMP_IOV] = reg_wdata[supply_fault_pkg::IOV_RISE_BIT];
			fall_sel_d[supply_fault_pkg::CMP_IOV] = reg_wdata[supply_fault_pkg::IOV_FALL_BIT];
		end
		if (wr_out) begin
			en_d[supply_fault_pkg::CMP_OOV] = reg_wdata[supply_fault_pkg::OOV_EN_BIT];
			rise_sel_d[supply_fault_pkg::CMP_OOV] = reg_wdata[supply_fault_pkg::OOV_RISE_BIT];
			fall_sel_d[supply_fault_pkg::CMP_OOV] = reg_wdata[supply_fault_pkg::OOV_FALL_BIT];
		end
		if (reg_wr && (reg_addr == supply_fault_pkg::ADDR_UV_THRESH)) begin
			uv_code_d = reg_wdata[supply_fault_pkg::CODE_W-1:0]; // RULE4 RULE19
		end
		if (reg_wr && (reg_addr == supply_fault_pkg::ADDR_OV_THRESH)) begin
			iov_code_d = reg_wdata[supply_fault_pkg::CODE_W-1:0]; // RULE5 RULE19
		end
		if (reg_wr && (reg_addr == supply_fault_pkg::ADDR_OUT_OV_LEVEL)) begin
			oov_code_d = reg_wdata; // RULE22
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			en_q <= '0;
			rise_sel_q <= '0;
			fall_sel_q <= '0;
			uv_code_q <= supply_fault_pkg::CODE_RST;
			iov_code_q <= supply_fault_pkg::CODE_RST;
			oov_code_q <= supply_fault_pkg::LEVEL_RST;
		end else begin
			en_q <= en_d;
			rise_sel_q <= rise_sel_d;
			fall_sel_q <= fall_sel_d;
			uv_code_q <= uv_code_d;
			iov_code_q <= iov_code_d;
			oov_code_q <= oov_code_d;
		end
	end

	// Gate driver override; output overvoltage takes priority over lockout
	always_comb begin
		pgate_d = primary_gate_req;
		sgate_d = secondary_gate_req;
		if ((en_q[supply_fault_pkg::CMP_UV] && sync2_q[supply_fault_pkg::CMP_UV]) ||
			(en_q[supply_fault_pkg::CMP_IOV] && sync2_q[supply_fault_pkg::CMP_IOV])) begin
			pgate_d = 1'b0; // RULE6 RULE7 RULE9
			sgate_d = 1'b0; // RULE7 RULE9
		end
		// Secondary on clamps the output while primary stays off
		if (en_q[supply_fault_pkg::CMP_OOV] && sync2_q[supply_fault_pkg::CMP_OOV]) begin
			pgate_d = 1'b0; // RULE17
			sgate_d = 1'b1; // RULE17
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pgate_q <= 1'b0;
			sgate_q <= 1'b0;
		end else begin
			pgate_q <= pgate_d;
			sgate_q <= sgate_d;
		end
	end

	// Read path; status bits are live levels so they clear on their own
	always_comb begin
		rdata_d = supply_fault_pkg::DATA_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				supply_fault_pkg::ADDR_LOCKOUT_CTRL: begin
					rdata_d[supply_fault_pkg::UV_EN_BIT] = en_q[supply_fault_pkg::CMP_UV];
					rdata_d[supply_fault_pkg::UV_STAT_BIT] =
						sync2_q[supply_fault_pkg::CMP_UV]; // RULE2 RULE8 RULE13
					rdata_d[supply_fault_pkg::UV_RISE_BIT] = rise_sel_q[supply_fault_pkg::CMP_UV];
					rdata_d[supply_fault_pkg::UV_FALL_BIT] = fall_sel_q[supply_fault_pkg::CMP_UV];
					rdata_d[supply_fault_pkg::IOV_EN_BIT] = en_q[supply_fault_pkg::CMP_IOV];
					rdata_d[supply_fault_pkg::IOV_STAT_BIT] =
						sync2_q[supply_fault_pkg::CMP_IOV]; // RULE3 RULE10
					rdata_d[supply_fault_pkg::IOV_RISE_BIT] = rise_sel_q[supply_fault_pkg::CMP_IOV];
					rdata_d[supply_fault_pkg::IOV_FALL_BIT] = fall_sel_q[supply_fault_pkg::CMP_IOV];
				end
				supply_fault_pkg::ADDR_UV_THRESH: begin
					rdata_d[supply_fault_pkg::CODE_W-1:0] = uv_code_q; // RULE19
				end
				supply_fault_pkg::ADDR_OV_THRESH: begin
					rdata_d[supply_fault_pkg::CODE_W-1:0] = iov_code_q; // RULE19
				end
				supply_fault_pkg::ADDR_OUT_OV_CTRL: begin
					rdata_d[supply_fault_pkg::OOV_EN_BIT] = en_q[supply_fault_pkg::CMP_OOV];
					rdata_d[supply_fault_pkg::OOV_STAT_BIT] =
						sync2_q[supply_fault_pkg::CMP_OOV]; // RULE21
					rdata_d[supply_fault_pkg::OOV_RISE_BIT] = rise_sel_q[supply_fault_pkg::CMP_OOV];
					rdata_d[supply_fault_pkg::OOV_FALL_BIT] = fall_sel_q[supply_fault_pkg::CMP_OOV];
				end
				supply_fault_pkg::ADDR_OUT_OV_LEVEL: begin
					rdata_d = oov_code_q;
				end
				supply_fault_pkg::ADDR_FLAGS: begin
					rdata_d[N-1:0] = flag_q;
				end
				default: begin
					rdata_d = supply_fault_pkg::DATA_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= supply_fault_pkg::DATA_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign undervolt_code = uv_code_q;
	assign input_overvolt_code = iov_code_q;
	assign output_overvolt_code = oov_code_q;
	assign primary_gate_out = pgate_q;
	assign secondary_gate_out = sgate_q;
	assign fault_flags = flag_q;
endmodule : supply_fault_lockout_logic

// [rtl/supply_fault_pkg.sv]
// Constants for the supply fault lockout block: register map, bit fields, reset values.
// Assumes a plain register port with read data one cycle after the read strobe.
// How it works
// RULE1: Input lockout flags ignore enables and global enable
// RULE2: Undervoltage status mirrors synchronized comparator level
// RULE3: Overvoltage status mirrors synchronized comparator level
// RULE4: Undervoltage threshold code is six bits
// RULE5: Input overvoltage threshold code is six bits
// RULE6: Undervoltage enable gates the lockout action
// RULE7: Undervoltage with enable forces both drivers off
// RULE8: Undervoltage status clears itself when voltage recovers
// RULE9: Input overvoltage with enable forces drivers off
// RULE10: Input overvoltage status clears itself automatically
// RULE11: Undervoltage flag follows rise and fall selects
// RULE12: Input overvoltage flag follows edge selects
// RULE13: Low input above core alive reports undervoltage
// RULE14: Firmware should poll undervoltage status bit
// RULE15: Firmware disables voltage amplifier before output protection
// RULE16: Output comparator result reported when sense higher
// RULE17: Output overvoltage drives secondary high, primary low
// RULE18: Output overvoltage flag ignores enables
// RULE19: Threshold upper two bits read zero
// RULE20: Output overvoltage flag follows edge selects
// RULE21: Output overvoltage status bit is read only
// RULE22: Output overvoltage level code is eight bits
// RULE23: Comparator inputs pass two synchronizing flip-flops
// RULE24: Flags stay set; set beats clear
package supply_fault_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_LOCKOUT_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_UV_THRESH = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_OV_THRESH = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_OUT_OV_CTRL = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_OUT_OV_LEVEL = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h5;
	// Lockout control fields
	localparam int UV_EN_BIT = 7;
	localparam int UV_STAT_BIT = 6;
	localparam int UV_RISE_BIT = 5;
	localparam int UV_FALL_BIT = 4;
	localparam int IOV_EN_BIT = 3;
	localparam int IOV_STAT_BIT = 2;
	localparam int IOV_RISE_BIT = 1;
	localparam int IOV_FALL_BIT = 0;
	// Output overvoltage control fields
	localparam int OOV_EN_BIT = 3;
	localparam int OOV_STAT_BIT = 2;
	localparam int OOV_RISE_BIT = 1;
	localparam int OOV_FALL_BIT = 0;
	// Flag register fields
	localparam int FLAG_UV_BIT = 0;
	localparam int FLAG_IOV_BIT = 1;
	localparam int FLAG_OOV_BIT = 2;
	localparam int CODE_W = 6;
	localparam int LEVEL_W = 8;
	localparam int NUM_CMP = 3;
	localparam int CMP_UV = 0;
	localparam int CMP_IOV = 1;
	localparam int CMP_OOV = 2;
	localparam logic [CODE_W-1:0] CODE_RST = 6'h00;
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
endpackage : supply_fault_pkg

// [test/fault_sense_model.sv]
// Far-side model: threshold DACs and comparators, voltages counted in code steps.
// Assumes the bench moves vin and vout only just after clock edges.
`timescale 1ns/1ps
module fault_sense_model (
	input wire logic [7:0] vin,
	input wire logic [7:0] vout,
	input wire logic [5:0] undervolt_code,
	input wire logic [5:0] input_overvolt_code,
	input wire logic [7:0] output_overvolt_code,
	output logic undervolt_cmp,
	output logic input_overvolt_cmp,
	output logic output_overvolt_cmp
);
	// Thresholds rise with code; lag keeps edges off the clock
	assign #3 undervolt_cmp = vin < {2'h0, undervolt_code};
	assign #3 input_overvolt_cmp = vin > {2'h0, input_overvolt_code};
	assign #3 output_overvolt_cmp = vout > output_overvolt_code;
endmodule : fault_sense_model

// [test/supply_fault_properties.sv]
// Port checker for the lockout block; snoops control writes to track enables and selects.
// Assumes comparator lines are still while reset is released.
`timescale 1ns/1ps
module supply_fault_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic undervolt_cmp,
	input wire logic input_overvolt_cmp,
	input wire logic output_overvolt_cmp,
	input wire logic primary_gate_req,
	input wire logic secondary_gate_req,
	input wire logic primary_gate_out,
	input wire logic secondary_gate_out,
	input wire logic [2:0] fault_flags
);
	logic [7:0] lc_q;
	logic [3:0] oc_q;
	logic [2:0] age_q;
	// Age keeps $past from reaching back into reset
	always_ff @(posedge clk) begin
		lc_q <= !rst_n ? 8'h00 : (reg_wr && reg_addr == 4'h0) ? reg_wdata : lc_q;
		oc_q <= !rst_n ? 4'h0 : (reg_wr && reg_addr == 4'h3) ? reg_wdata[3:0] : oc_q;
		age_q <= !rst_n ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
	end
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_edge(c, r, f);
		age_q == 3'h7 && ((r && $past(c, 3) && !$past(c, 4)) || (f && !$past(c, 3) && $past(c, 4)));
	endsequence
	sequence s_held(en, c);
		age_q == 3'h7 && en && $past(en) && $past(c, 3) && $past(c, 4);
	endsequence
	property p_uv_lock;
		s_held(lc_q[7] && !oc_q[3], undervolt_cmp) |-> !primary_gate_out && !secondary_gate_out;
	endproperty
	property p_iov_lock;
		s_held(lc_q[3] && !oc_q[3], input_overvolt_cmp) |-> !primary_gate_out && !secondary_gate_out;
	endproperty
	property p_oov_force;
		s_held(oc_q[3], output_overvolt_cmp) |-> !primary_gate_out && secondary_gate_out;
	endproperty
	property p_pass;
		age_q == 3'h7 && !(lc_q[7] || lc_q[3] || oc_q[3]) && !$past(lc_q[7] || lc_q[3] || oc_q[3])
			|-> primary_gate_out == $past(primary_gate_req)
			&& secondary_gate_out == $past(secondary_gate_req);
	endproperty
	property p_sticky;
		age_q != 3'h0 && !($past(reg_wr) && $past(reg_addr) == 4'h5)
			|-> (fault_flags & $past(fault_flags)) == $past(fault_flags);
	endproperty
	property p_uv_flag;
		s_edge(undervolt_cmp, $past(lc_q[5]), $past(lc_q[4])) |-> fault_flags[0];
	endproperty
	property p_iov_flag;
		s_edge(input_overvolt_cmp, $past(lc_q[1]), $past(lc_q[0])) |-> fault_flags[1];
	endproperty
	property p_oov_flag;
		s_edge(output_overvolt_cmp, $past(oc_q[1]), $past(oc_q[0])) |-> fault_flags[2];
	endproperty
	a_uv_lock: assert property (p_uv_lock) else $error("uv lockout missed");
	a_iov_lock: assert property (p_iov_lock) else $error("ov lockout missed");
	a_oov_force: assert property (p_oov_force) else $error("out ov drive wrong");
	a_pass: assert property (p_pass) else $error("gate pass wrong");
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	a_uv_flag: assert property (p_uv_flag) else $error("uv flag missed");
	a_iov_flag: assert property (p_iov_flag) else $error("ov flag missed");
	a_oov_flag: assert property (p_oov_flag) else $error("out flag missed");
endmodule : supply_fault_properties
bind supply_fault_lockout_logic supply_fault_properties supply_fault_properties_inst (.clk, .rst_n,
	.reg_addr, .reg_wdata, .reg_wr, .undervolt_cmp, .input_overvolt_cmp, .output_overvolt_cmp,
	.primary_gate_req, .secondary_gate_req, .primary_gate_out, .secondary_gate_out, .fault_flags);

// [test/tb.sv]
// Bench for the lockout block: register tasks, comparators moved through the far-side model.
// Assumes the model file and the bound checker.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic primary_gate_req = 1'b0;
	logic secondary_gate_req = 1'b1;
	logic [7:0] vin = 8'h00;
	logic [7:0] vout = 8'h00;
	logic [7:0] reg_rdata;
	logic undervolt_cmp;
	logic input_overvolt_cmp;
	logic output_overvolt_cmp;
	logic [5:0] undervolt_code;
	logic [5:0] input_overvolt_code;
	logic [7:0] output_overvolt_code;
	logic primary_gate_out;
	logic secondary_gate_out;
	logic [2:0] fault_flags;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	supply_fault_lockout_logic supply_fault_lockout_logic_inst (.clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .undervolt_cmp, .input_overvolt_cmp,
		.output_overvolt_cmp, .primary_gate_req, .secondary_gate_req, .undervolt_code,
		.input_overvolt_code, .output_overvolt_code, .primary_gate_out, .secondary_gate_out,
		.fault_flags);
	fault_sense_model fault_sense_model_inst (.vin, .vout, .undervolt_code, .input_overvolt_code,
		.output_overvolt_code, .undervolt_cmp, .input_overvolt_cmp, .output_overvolt_cmp);
	initial forever #4 clk = ~clk;
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	// Toggling requests show whether the gates pass them through
	always @(posedge clk) begin
		cycles++;
		primary_gate_req <= ~primary_gate_req;
		secondary_gate_req <= ~secondary_gate_req;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", exp, reg_rdata);
	endtask : rd
	// Comparator k to level v, then time for the synchronizer
	task automatic set_cmp(input int k, input logic v);
		@(posedge clk);
		vin <= (k == 2) ? vin : (v ? ((k == 0) ? 8'h08 : 8'h38) : 8'h20);
		vout <= (k == 2 && v) ? 8'h90 : 8'h10;
		repeat (6) @(posedge clk);
	endtask : set_cmp
	initial begin
		logic [3:0] a;
		logic [7:0] c;
		int sh;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) rd(4'(i), 8'h00);
		$display("test reset values done");
		vin <= 8'h20;
		wr(4'h1, 8'hFF);
		wr(4'h2, 8'hC5);
		wr(4'h4, 8'hA5);
		rd(4'h1, 8'h3F);
		rd(4'h2, 8'h05);
		rd(4'h4, 8'hA5);
		chk("codes", {6'h3F, 6'h05, 8'hA5}, {undervolt_code, input_overvolt_code, output_overvolt_code});
		wr(4'h1, 8'h10);
		wr(4'h2, 8'h30);
		wr(4'h4, 8'h80);
		$display("test threshold codes done");
		// Voltage amplifier counts as disabled before any output OV use
		// Rise-only pass runs enabled, fall-only pass disabled; status write bit must not stick
		for (int k = 0; k < 3; k++) begin
			for (int p = 0; p < 2; p++) begin
				a = (k == 2) ? 4'h3 : 4'h0;
				sh = (k == 0) ? 4 : 0;
				c = {4'h0, ~p[0], 1'b1, ~p[0], p[0]} << sh;
				wr(a, c);
				wr(4'h5, 8'h00);
				set_cmp(k, 1'b1);
				rd(a, c);
				rd(4'h5, {7'h0, ~p[0]} << k);
				if (p == 0) chk("gates", {19'h0, k == 2}, {primary_gate_out, secondary_gate_out});
				wr(4'h5, 8'h00);
				set_cmp(k, 1'b0);
				rd(a, c & ~(8'h04 << sh));
				rd(4'h5, {7'h0, p[0]} << k);
				chk("fault_flags", {7'h0, p[0]} << k, fault_flags);
				wr(a, 8'h00);
			end
		end
		$display("test comparator edges done");
		test_done();
	end
endmodule : tb
